// ---- rtl/wpc_cfg.svh ----
// constants for the wake-up phase and capacitance compare block
`ifndef WPC_CFG_SVH
`define WPC_CFG_SVH
// offsets are word indices: the byte address is four times the index
`define WPC_PHASE_CFG_OFS 8'h36
`define WPC_PHASE_REF_OFS 8'h37
`define WPC_PHASE_AVG_OFS 8'h38
`define WPC_PHASE_LAST_OFS 8'h39
`define WPC_CAP_CFG_OFS 8'h3a
`define WPC_CAP_REF_OFS 8'h3b
`define WPC_CAP_AVG_OFS 8'h3c
`define WPC_CAP_LAST_OFS 8'h3d
`define WPC_WAKE_CTRL_OFS 8'h40
`define WPC_IRQ_STATUS_OFS 8'h44
`define WPC_IRQ_MASK_OFS 8'h48
`define WPC_COMMAND_OFS 8'h4c
`define WPC_REG_RESET 8'h00
`define WPC_DELTA_MSB 7
`define WPC_DELTA_LSB 4
`define WPC_INCLUDE_BIT 3
`define WPC_WEIGHT_MSB 2
`define WPC_WEIGHT_LSB 1
`define WPC_REF_SEL_BIT 0
`define WPC_CTRL_PHASE_BIT 1
`define WPC_CTRL_CAP_BIT 0
`define WPC_IRQ_PHASE_BIT 1
`define WPC_IRQ_CAP_BIT 0
`define WPC_CMD_SET_DEFAULT_BIT 0
`define WPC_SHIFT_BASE 3'h2
`define WPC_ADDR_MSB 9
`define WPC_ADDR_LSB 2
`endif

// ---- rtl/wpc_pkg.sv ----
// types for the wake-up phase and capacitance compare block
package wpc_pkg;
	typedef struct packed {
		logic [3:0] delta_threshold;
		logic avg_include_trigger;
		logic [1:0] avg_weight;
		logic ref_from_average;
	} wpc_chan_cfg_type;
	typedef struct packed {
		logic valid;
		logic [7:0] value;
	} wpc_meas_type;
	typedef enum logic [1:0] {
		wpc_bus_idle_type_s = 2'b00,
		wpc_bus_write_type_s = 2'b01,
		wpc_bus_read_type_s = 2'b10
	} wpc_bus_state_type;
endpackage

// ---- rtl/wpc_channel.sv ----
// one compare channel: reference select, delta check, running average
`timescale 1ns/1ps
`include "wpc_cfg.svh"
module wpc_channel (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	// configuration
	input wire wpc_pkg::wpc_chan_cfg_type cfg,
	input wire logic [7:0] fixed_reference,
	// measurement
	input wire wpc_pkg::wpc_meas_type meas,
	// results
	output logic [7:0] average_value,
	output logic [7:0] last_value,
	output logic trigger
);
	import wpc_pkg::*;
	logic [7:0] reference;
	logic [7:0] diff;
	logic over;
	logic [2:0] shift;
	logic [8:0] step;
	logic [7:0] next_average;

	assign reference = cfg.ref_from_average ? average_value : fixed_reference;
	assign diff = (meas.value >= reference) ? meas.value - reference : reference - meas.value;
	assign over = diff > {4'h0, cfg.delta_threshold};
	assign shift = `WPC_SHIFT_BASE + {1'b0, cfg.avg_weight};
	// rounds toward the stored average, so the result always stays in 8 bits
	always_comb begin
		step = 9'h000;
		next_average = average_value;
		if (meas.value >= average_value) begin
			step = {1'b0, meas.value - average_value} >> shift;
			next_average = average_value + step[7:0];
		end else begin
			step = {1'b0, average_value - meas.value} >> shift;
			next_average = average_value - step[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_value <= `WPC_REG_RESET;
		end else if (clear) begin
			last_value <= `WPC_REG_RESET;
		end else if (meas.valid) begin
			last_value <= meas.value;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			average_value <= `WPC_REG_RESET;
		end else if (clear) begin
			average_value <= `WPC_REG_RESET;
		end else if (meas.valid && (!over || cfg.avg_include_trigger)) begin
			average_value <= next_average;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trigger <= 1'b0;
		end else begin
			trigger <= meas.valid && over && !clear;
		end
	end
endmodule

// ---- rtl/wpc_top.sv ----
// wake-up phase and capacitance compare block with an AHB-Lite register slave
// Operation
// - phase config bits 7..4 hold the phase delta threshold
// - cap config bits 7..4 hold the cap delta threshold
// - phase config bit 3 includes over-delta measurements in the average
// - cap config bit 3 includes over-delta measurements in the average
// - config bits 2..1 pick average weight 4, 8, 16 or 32
// - phase config bit 0 picks average or fixed reference
// - cap config bit 0 picks average or fixed reference
// - config and reference registers clear at reset and set-default
// - average and last result registers clear at reset and set-default
// - phase fixed reference is read-write at 37h
// - cap fixed reference is read-write at 3Bh
// - phase average is read-only at 38h
// - phase last result is read-only at 39h
// - cap average is read-only at 3Ch
// - cap last result is read-only at 3Dh
// - phase config at 36h, cap config at 3Ah, both read-write
// - enabled phase sensing measures each timeout, flags over-delta
// - enabled cap sensing measures each timeout, flags over-delta
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "wpc_cfg.svh"
module wpc_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// wake-up timer and measurement front end
	input wire logic wake_timeout,
	input wire wpc_pkg::wpc_meas_type phase_meas_in,
	input wire wpc_pkg::wpc_meas_type cap_meas_in,
	output logic phase_meas_start,
	output logic cap_meas_start,
	// interrupt
	output logic irq
);
	import wpc_pkg::*;
	logic [7:0] phase_wake_config;
	logic [7:0] phase_wake_reference;
	logic [7:0] cap_wake_config;
	logic [7:0] cap_wake_reference;
	logic [1:0] wake_ctrl;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [7:0] phase_running_average;
	logic [7:0] phase_last_result;
	logic [7:0] cap_running_average;
	logic [7:0] cap_last_result;
	logic phase_trigger;
	logic cap_trigger;
	logic set_default;
	wpc_bus_state_type bus_state;
	logic [7:0] addr_q;
	logic wr_en;
	logic [7:0] wdata;
	logic [31:0] next_rdata;
	wpc_chan_cfg_type phase_cfg;
	wpc_chan_cfg_type cap_cfg;
	wpc_meas_type phase_meas;
	wpc_meas_type cap_meas;
	logic [1:0] events;

	// field mapping shared by both channels
	assign phase_cfg.delta_threshold = phase_wake_config[`WPC_DELTA_MSB:`WPC_DELTA_LSB];
	assign phase_cfg.avg_include_trigger = phase_wake_config[`WPC_INCLUDE_BIT];
	assign phase_cfg.avg_weight = phase_wake_config[`WPC_WEIGHT_MSB:`WPC_WEIGHT_LSB];
	assign phase_cfg.ref_from_average = phase_wake_config[`WPC_REF_SEL_BIT];
	assign cap_cfg.delta_threshold = cap_wake_config[`WPC_DELTA_MSB:`WPC_DELTA_LSB];
	assign cap_cfg.avg_include_trigger = cap_wake_config[`WPC_INCLUDE_BIT];
	assign cap_cfg.avg_weight = cap_wake_config[`WPC_WEIGHT_MSB:`WPC_WEIGHT_LSB];
	assign cap_cfg.ref_from_average = cap_wake_config[`WPC_REF_SEL_BIT];

	// results only count while that sensing is enabled
	assign phase_meas.valid = phase_meas_in.valid && wake_ctrl[`WPC_CTRL_PHASE_BIT];
	assign phase_meas.value = phase_meas_in.value;
	assign cap_meas.valid = cap_meas_in.valid && wake_ctrl[`WPC_CTRL_CAP_BIT];
	assign cap_meas.value = cap_meas_in.value;

	// ahb-lite: zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= wpc_bus_idle_type_s;
			addr_q <= 8'h00;
		end else if (hready) begin
			addr_q <= haddr[`WPC_ADDR_MSB:`WPC_ADDR_LSB];
			if (hsel && htrans[1]) begin
				bus_state <= hwrite ? wpc_bus_write_type_s : wpc_bus_read_type_s;
			end else begin
				bus_state <= wpc_bus_idle_type_s;
			end
		end
	end

	assign wr_en = (bus_state == wpc_bus_write_type_s);
	assign wdata = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// read data registered in the address phase so hrdata comes from a flop
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (haddr[`WPC_ADDR_MSB:`WPC_ADDR_LSB])
			`WPC_PHASE_CFG_OFS: begin
				next_rdata[7:0] = phase_wake_config;
			end
			`WPC_PHASE_REF_OFS: begin
				next_rdata[7:0] = phase_wake_reference;
			end
			`WPC_PHASE_AVG_OFS: begin
				next_rdata[7:0] = phase_running_average;
			end
			`WPC_PHASE_LAST_OFS: begin
				next_rdata[7:0] = phase_last_result;
			end
			`WPC_CAP_CFG_OFS: begin
				next_rdata[7:0] = cap_wake_config;
			end
			`WPC_CAP_REF_OFS: begin
				next_rdata[7:0] = cap_wake_reference;
			end
			`WPC_CAP_AVG_OFS: begin
				next_rdata[7:0] = cap_running_average;
			end
			`WPC_CAP_LAST_OFS: begin
				next_rdata[7:0] = cap_last_result;
			end
			`WPC_WAKE_CTRL_OFS: begin
				next_rdata[1:0] = wake_ctrl;
			end
			`WPC_IRQ_STATUS_OFS: begin
				next_rdata[1:0] = irq_status;
			end
			`WPC_IRQ_MASK_OFS: begin
				next_rdata[1:0] = irq_mask;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
		// a write still in its data phase has not landed yet, so a read right behind it sees its data
		if (set_default) begin
			next_rdata = 32'h0000_0000;
		end else if (wr_en && (addr_q == haddr[`WPC_ADDR_MSB:`WPC_ADDR_LSB])) begin
			case (addr_q)
				`WPC_PHASE_CFG_OFS, `WPC_PHASE_REF_OFS, `WPC_CAP_CFG_OFS, `WPC_CAP_REF_OFS: begin
					next_rdata[7:0] = wdata;
				end
				`WPC_WAKE_CTRL_OFS, `WPC_IRQ_MASK_OFS: begin
					next_rdata[1:0] = wdata[1:0];
				end
				`WPC_IRQ_STATUS_OFS: begin
					next_rdata[1:0] = irq_status & ~wdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// acts in the command's own data phase, so a write right behind it is not lost
	assign set_default = wr_en && (addr_q == `WPC_COMMAND_OFS) && wdata[`WPC_CMD_SET_DEFAULT_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_wake_config <= `WPC_REG_RESET;
			phase_wake_reference <= `WPC_REG_RESET;
			cap_wake_config <= `WPC_REG_RESET;
			cap_wake_reference <= `WPC_REG_RESET;
		end else if (set_default) begin
			phase_wake_config <= `WPC_REG_RESET;
			phase_wake_reference <= `WPC_REG_RESET;
			cap_wake_config <= `WPC_REG_RESET;
			cap_wake_reference <= `WPC_REG_RESET;
		end else if (wr_en) begin
			if (addr_q == `WPC_PHASE_CFG_OFS) begin
				phase_wake_config <= wdata;
			end
			if (addr_q == `WPC_PHASE_REF_OFS) begin
				phase_wake_reference <= wdata;
			end
			if (addr_q == `WPC_CAP_CFG_OFS) begin
				cap_wake_config <= wdata;
			end
			if (addr_q == `WPC_CAP_REF_OFS) begin
				cap_wake_reference <= wdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_ctrl <= 2'b00;
			irq_mask <= 2'b00;
		end else if (set_default) begin
			wake_ctrl <= 2'b00;
			irq_mask <= 2'b00;
		end else if (wr_en) begin
			if (addr_q == `WPC_WAKE_CTRL_OFS) begin
				wake_ctrl <= wdata[1:0];
			end
			if (addr_q == `WPC_IRQ_MASK_OFS) begin
				irq_mask <= wdata[1:0];
			end
		end
	end

	// start pulses follow the timer, one per enabled channel
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_meas_start <= 1'b0;
			cap_meas_start <= 1'b0;
		end else begin
			phase_meas_start <= wake_timeout && wake_ctrl[`WPC_CTRL_PHASE_BIT];
			cap_meas_start <= wake_timeout && wake_ctrl[`WPC_CTRL_CAP_BIT];
		end
	end

	wpc_channel u_phase (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(set_default),
		.cfg(phase_cfg),
		.fixed_reference(phase_wake_reference),
		.meas(phase_meas),
		.average_value(phase_running_average),
		.last_value(phase_last_result),
		.trigger(phase_trigger)
	);

	wpc_channel u_cap (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(set_default),
		.cfg(cap_cfg),
		.fixed_reference(cap_wake_reference),
		.meas(cap_meas),
		.average_value(cap_running_average),
		.last_value(cap_last_result),
		.trigger(cap_trigger)
	);

	// a new event wins over a write-one clear in the same cycle
	assign events = {phase_trigger, cap_trigger};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= 2'b00;
		end else if (set_default) begin
			irq_status <= 2'b00;
		end else begin
			if (wr_en && (addr_q == `WPC_IRQ_STATUS_OFS)) begin
				irq_status <= (irq_status & ~wdata[1:0]) | events;
			end else begin
				irq_status <= irq_status | events;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule

// ---- verification/wpc_top_chk.sv ----
// port assertions for the compare block
`timescale 1ns/1ps
module wpc_top_chk (
	// watched ports
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic wake_timeout,
	input wire wpc_pkg::wpc_meas_type phase_meas_in,
	input wire wpc_pkg::wpc_meas_type cap_meas_in,
	input wire logic phase_meas_start,
	input wire logic cap_meas_start,
	input wire logic irq
);
	import wpc_pkg::*;
	logic req;
	logic hit;
	assign req = hsel && hready && htrans[1];
	assign hit = haddr[9:2] inside {[8'h36:8'h3d], 8'h40, 8'h44, 8'h48, 8'h4c};
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_rd_miss;
		req && !hwrite && !hit;
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
	chk_ready_high: assert property (hreadyout) else $error("wait state seen");
	chk_rdata_narrow: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper bits set");
	chk_miss_zero: assert property (s_rd_miss |=> hrdata == 32'h0) else $error("unmapped read not zero");
	chk_phase_start: assert property (phase_meas_start |-> $past(wake_timeout)) else $error("stray phase start");
	chk_cap_start: assert property (cap_meas_start |-> $past(wake_timeout)) else $error("stray cap start");
	// a mask write can raise irq as well as a measurement
	chk_irq_rise: assert property ($rose(irq) |->
		$past(phase_meas_in.valid || cap_meas_in.valid || (req && hwrite), 3)) else $error("irq rose without cause");
	chk_irq_fall: assert property ($fell(irq) |-> $past(req && hwrite, 3)) else $error("irq fell without write");
endmodule

// ---- verification/wpc_top_tb.sv ----
// self-checking bench for the compare block
`timescale 1ns/1ps
`include "wpc_cfg.svh"
module wpc_top_tb;
	import wpc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic wake_timeout = 1'b0;
	wpc_meas_type phase_meas_in = '0;
	wpc_meas_type cap_meas_in = '0;
	logic phase_meas_start;
	logic cap_meas_start;
	logic irq;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [7:0] rd;
	always #50 hclk = ~hclk;
	wpc_top wpc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .wake_timeout(wake_timeout), .phase_meas_in(phase_meas_in),
		.cap_meas_in(cap_meas_in), .phase_meas_start(phase_meas_start), .cap_meas_start(cap_meas_start), .irq(irq));
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// single transfer; master waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, a, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check8($sformatf("reg %h", a), exp, rd);
	endtask
	// timeout pulse, start check, then one result
	task automatic meas(input logic ph, input logic [7:0] v);
		wake_timeout <= 1'b1;
		@(posedge hclk);
		wake_timeout <= 1'b0;
		#1 check8("start", {6'h0, ph, !ph}, {6'h0, phase_meas_start, cap_meas_start});
		@(posedge hclk);
		phase_meas_in <= {ph, v};
		cap_meas_in <= {!ph, v};
		@(posedge hclk);
		phase_meas_in <= '0;
		cap_meas_in <= '0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic t_access;
		for (int a = 'h36; a <= 'h3d; a++) begin
			rdchk(8'(a), 8'h00);
			bus(1'b1, 8'(a), 8'(a) ^ 8'ha5);
		end
		bus(1'b1, 8'h50, 8'hff);
		rdchk(8'h50, 8'h00);
		for (int a = 'h36; a <= 'h3d; a++) begin
			rdchk(8'(a), a[1] ? 8'(a) ^ 8'ha5 : 8'h00);
		end
		$display("test access done");
	endtask
	task automatic t_phase;
		bus(1'b1, `WPC_PHASE_CFG_OFS, 8'h20);
		bus(1'b1, `WPC_PHASE_REF_OFS, 8'h40);
		bus(1'b1, `WPC_WAKE_CTRL_OFS, 8'h02);
		bus(1'b1, `WPC_IRQ_MASK_OFS, 8'h02);
		meas(1'b1, 8'h42);
		check8("irq", 8'h00, {7'h0, irq});
		rdchk(`WPC_PHASE_LAST_OFS, 8'h42);
		rdchk(`WPC_PHASE_AVG_OFS, 8'h10);
		meas(1'b1, 8'h43);
		check8("irq", 8'h01, {7'h0, irq});
		rdchk(`WPC_PHASE_AVG_OFS, 8'h10);
		rdchk(`WPC_IRQ_STATUS_OFS, 8'h02);
		bus(1'b1, `WPC_IRQ_STATUS_OFS, 8'h02);
		repeat (2) @(posedge hclk);
		check8("irq", 8'h00, {7'h0, irq});
		// near the average but far from the fixed reference
		bus(1'b1, `WPC_PHASE_CFG_OFS, 8'h21);
		meas(1'b1, 8'h12);
		check8("irq", 8'h00, {7'h0, irq});
		$display("test phase done");
	endtask
	task automatic t_cap;
		for (int w = 0; w < 4; w++) begin
			bus(1'b1, `WPC_COMMAND_OFS, 8'h01);
			repeat (2) @(posedge hclk);
			rdchk(`WPC_CAP_AVG_OFS, 8'h00);
			rdchk(`WPC_PHASE_CFG_OFS, 8'h00);
			rdchk(`WPC_PHASE_REF_OFS, 8'h00);
			rdchk(`WPC_CAP_LAST_OFS, 8'h00);
			bus(1'b1, `WPC_CAP_CFG_OFS, {4'h1, 1'b1, 2'(w), 1'b1});
			bus(1'b1, `WPC_WAKE_CTRL_OFS, 8'h01);
			bus(1'b1, `WPC_IRQ_MASK_OFS, 8'h01);
			meas(1'b0, 8'h80);
			check8("irq", 8'h01, {7'h0, irq});
			rdchk(`WPC_CAP_LAST_OFS, 8'h80);
			rdchk(`WPC_CAP_AVG_OFS, 8'h20 >> w);
		end
		$display("test cap done");
	endtask
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_access();
		t_phase();
		t_cap();
		close_out();
	end
endmodule
bind wpc_top wpc_top_chk wpc_top_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.wake_timeout(wake_timeout), .phase_meas_in(phase_meas_in), .cap_meas_in(cap_meas_in),
	.phase_meas_start(phase_meas_start), .cap_meas_start(cap_meas_start), .irq(irq));
